// ### src/bsf_device.sv
// device end: sample fifo with its handling registers behind the link
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module bsf_device
  import bsf_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // link
  bsf_link_if.dev link,
  // acquisition side
  input wire logic sampleStrobe,
  input wire logic [18:0] opt1Data,
  input wire logic [18:0] opt2Data,
  input wire logic [17:0] cardData,
  input wire logic proximityMode,
  // status
  output logic nearFullIrq,
  output logic fifoEnabled
);
  // ----------------------------------------------------------------
  // link input synchronisers
  // ----------------------------------------------------------------
  logic [12:0] s1_q, s2_q, s3_q;
  logic clkLvl_q, clkLvl_d, proxLvl_q, proxLvl_d;
  logic linkEdge, proxChange;

  always_comb
  begin
    // a level counts only once stages two and three agree
    clkLvl_d = (s2_q[11] == s3_q[11]) ? s3_q[11] : clkLvl_q;
    proxLvl_d = (s2_q[12] == s3_q[12]) ? s3_q[12] : proxLvl_q;
    linkEdge = clkLvl_d && !clkLvl_q;
    proxChange = proxLvl_d != proxLvl_q;
  end

  // ----------------------------------------------------------------
  // registers and storage
  // ----------------------------------------------------------------
  logic [23:0] mem [0:127];
  logic [4:0] wrIdx_q, wrIdx_d, rdIdx_q, rdIdx_d, lost_q, lost_d;
  logic full_q, full_d, nearFull_q, nearFull_d;
  logic [7:0] setup_q, setup_d, slotsLo_q, slotsLo_d, slotsHi_q, slotsHi_d;
  logic [7:0] sysCtl_q, sysCtl_d, irqEn_q, irqEn_d, regAddr_q, regAddr_d;
  logic [7:0] outByte_q, outByte_d;
  logic [1:0] elemIdx_q, elemIdx_d, byteSel_q, byteSel_d;

  // ----------------------------------------------------------------
  // slot decode
  // ----------------------------------------------------------------
  logic [3:0] slotCode [SLOT_COUNT];
  logic [23:0] elemData [SLOT_COUNT];
  logic [SLOT_COUNT-1:0] slotOn;
  logic [2:0] nElem;

  assign slotCode[0] = slotsLo_q[3:0];
  assign slotCode[1] = slotsLo_q[7:4];
  assign slotCode[2] = slotsHi_q[3:0];
  assign slotCode[3] = slotsHi_q[7:4];

  generate
    for (genvar g = 0; g < SLOT_COUNT; g++)
    begin : gSlot
      always_comb
      begin
        unique case (slotCode[g])
          SLOT_OPT1: elemData[g] = {5'h0, opt1Data};
          SLOT_OPT2: elemData[g] = {5'h0, opt2Data};
          SLOT_CARD: elemData[g] = {6'h0, cardData};
          default: elemData[g] = 24'h0;
        endcase
      end
      if (g == 0)
      begin : gFirst
        assign slotOn[g] = slotCode[g] == SLOT_OPT1 ||
          slotCode[g] == SLOT_OPT2 || slotCode[g] == SLOT_CARD;
      end
      else
      begin : gRest
        assign slotOn[g] = slotOn[g-1] && (slotCode[g] == SLOT_OPT1 ||
          slotCode[g] == SLOT_OPT2 || slotCode[g] == SLOT_CARD);
      end
    end
  endgenerate

  assign nElem = 3'(slotOn[0]) + 3'(slotOn[1]) + 3'(slotOn[2]) +
    3'(slotOn[3]);

  // ----------------------------------------------------------------
  // fifo control and register access
  // ----------------------------------------------------------------
  logic push, pop, empty, flush, memWe;
  logic doRd, doWr, doStart;
  logic [7:0] ldat, regVal, dataByte;
  logic [23:0] headElem;
  logic [5:0] cnt;

  assign fifoEnabled = sysCtl_q[FIFO_ENABLE_BIT];
  assign ldat = s2_q[7:0];
  assign doRd = linkEdge && s2_q[8];
  assign doWr = linkEdge && s2_q[9];
  assign doStart = linkEdge && s2_q[10];
  assign empty = !full_q && wrIdx_q == rdIdx_q;
  assign headElem = mem[{rdIdx_q, elemIdx_q}];

  always_comb
  begin
    unique case (byteSel_q)
      2'h0: dataByte = headElem[23:16];
      2'h1: dataByte = headElem[15:8];
      default: dataByte = headElem[7:0];
    endcase
    unique case (regAddr_q)
      REG_STATUS_OFS: regVal = {nearFull_q, 7'h0};
      REG_IRQ_EN_OFS: regVal = irqEn_q;
      REG_WR_INDEX_OFS: regVal = {3'h0, wrIdx_q};
      REG_LOST_OFS: regVal = {3'h0, lost_q};
      REG_RD_INDEX_OFS: regVal = {3'h0, rdIdx_q};
      REG_DATA_PORT_OFS: regVal = empty ? 8'h0 : dataByte;
      REG_SETUP_OFS: regVal = setup_q;
      REG_SLOTS_LO_OFS: regVal = slotsLo_q;
      REG_SLOTS_HI_OFS: regVal = slotsHi_q;
      REG_SYS_CTL_OFS: regVal = sysCtl_q;
      default: regVal = 8'h0;
    endcase
  end

  always_comb
  begin
    wrIdx_d = wrIdx_q;
    rdIdx_d = rdIdx_q;
    lost_d = lost_q;
    full_d = full_q;
    nearFull_d = nearFull_q;
    setup_d = setup_q;
    slotsLo_d = slotsLo_q;
    slotsHi_d = slotsHi_q;
    sysCtl_d = sysCtl_q;
    irqEn_d = irqEn_q;
    regAddr_d = regAddr_q;
    outByte_d = outByte_q;
    elemIdx_d = elemIdx_q;
    byteSel_d = byteSel_q;
    pop = 1'b0;
    flush = 1'b0;
    memWe = 1'b0;
    cnt = 6'h0;
    push = sampleStrobe && fifoEnabled && nElem != 3'h0;
    // a new transaction restarts any partly read sample from its first byte
    if (doStart)
    begin
      regAddr_d = ldat;
      elemIdx_d = 2'h0;
      byteSel_d = 2'h0;
    end
    if (doRd)
    begin
      outByte_d = regVal;
      if (regAddr_q == REG_STATUS_OFS)
      begin
        nearFull_d = 1'b0;
      end
      // address pointer holds on the data port
      if (regAddr_q == REG_DATA_PORT_OFS)
      begin
        if (!empty)
        begin
          byteSel_d = byteSel_q + 2'h1;
          if (byteSel_q == 2'(BYTES_PER_ELEM - 1))
          begin
            byteSel_d = 2'h0;
            elemIdx_d = elemIdx_q + 2'h1;
            // pop only after the last byte
            if (3'(elemIdx_q) == nElem - 3'h1)
            begin
              elemIdx_d = 2'h0;
              pop = 1'b1;
            end
          end
        end
      end
      else
      begin
        regAddr_d = regAddr_q + 8'h1;
      end
    end
    // a pop clears the lost count
    if (pop)
    begin
      rdIdx_d = rdIdx_q + 5'h1;
      lost_d = 5'h0;
      full_d = 1'b0;
    end
    if (push)
    begin
      if (full_q && !pop)
      begin
        if (lost_q != LOST_MAX)
        begin
          lost_d = lost_q + 5'h1;
        end
        if (setup_q[OVERWRITE_BIT])
        begin
          memWe = 1'b1;
          wrIdx_d = wrIdx_q + 5'h1;
          rdIdx_d = rdIdx_q + 5'h1;
          elemIdx_d = 2'h0;
          byteSel_d = 2'h0;
        end
      end
      else
      begin
        memWe = 1'b1;
        wrIdx_d = wrIdx_q + 5'h1;
        full_d = wrIdx_d == rdIdx_d;
      end
      cnt = full_d ? FIFO_SAMPLES : {1'b0, wrIdx_d - rdIdx_d};
      // set when free space reaches threshold
      if (FIFO_SAMPLES - cnt <= {2'h0, setup_q[3:0]})
      begin
        nearFull_d = 1'b1;
      end
    end
    if (doWr)
    begin
      regAddr_d = regAddr_q + 8'h1;
      unique case (regAddr_q)
        REG_IRQ_EN_OFS: irqEn_d = ldat;
        REG_WR_INDEX_OFS:
        begin
          wrIdx_d = ldat[4:0];
          full_d = 1'b0;
        end
        REG_RD_INDEX_OFS:
        begin
          rdIdx_d = ldat[4:0];
          full_d = 1'b0;
          elemIdx_d = 2'h0;
          byteSel_d = 2'h0;
        end
        REG_SETUP_OFS: setup_d = ldat;
        REG_SLOTS_LO_OFS: slotsLo_d = ldat;
        REG_SLOTS_HI_OFS: slotsHi_d = ldat;
        REG_SYS_CTL_OFS: sysCtl_d = ldat;
        default: ;
      endcase
      flush = fifoEnabled && (regAddr_q == REG_SLOTS_LO_OFS ||
        regAddr_q == REG_SLOTS_HI_OFS ||
        (regAddr_q >= REG_OPT_CFG_FIRST && regAddr_q <= REG_OPT_CFG_LAST) ||
        (regAddr_q >= REG_CARD_CFG_FIRST &&
        regAddr_q <= REG_CARD_CFG_LAST));
      if (regAddr_q == REG_SYS_CTL_OFS && !fifoEnabled &&
        ldat[FIFO_ENABLE_BIT])
      begin
        flush = 1'b1;
      end
    end
    if (flush || (proxChange && fifoEnabled))
    begin
      wrIdx_d = 5'h0;
      rdIdx_d = 5'h0;
      full_d = 1'b0;
      elemIdx_d = 2'h0;
      byteSel_d = 2'h0;
      memWe = 1'b0;
    end
  end

  // slot n to element index n
  always_ff @(posedge core_clk)
  begin
    for (int k = 0; k < SLOT_COUNT; k++)
    begin
      if (memWe && slotOn[k])
      begin
        mem[{wrIdx_q, 2'(k)}] <= elemData[k];
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= 13'h0;
      s2_q <= 13'h0;
      s3_q <= 13'h0;
      clkLvl_q <= 1'b0;
      proxLvl_q <= 1'b0;
      wrIdx_q <= 5'h0;
      rdIdx_q <= 5'h0;
      lost_q <= 5'h0;
      full_q <= 1'b0;
      nearFull_q <= 1'b0;
      setup_q <= REG_RESET_VAL;
      slotsLo_q <= REG_RESET_VAL;
      slotsHi_q <= REG_RESET_VAL;
      sysCtl_q <= REG_RESET_VAL;
      irqEn_q <= REG_RESET_VAL;
      regAddr_q <= REG_RESET_VAL;
      outByte_q <= REG_RESET_VAL;
      elemIdx_q <= 2'h0;
      byteSel_q <= 2'h0;
    end
    else
    begin
      s1_q <= {proximityMode, link.lclk, link.lstart, link.lwr, link.lrd,
        link.ldata};
      s2_q <= s1_q;
      s3_q <= s2_q;
      clkLvl_q <= clkLvl_d;
      proxLvl_q <= proxLvl_d;
      wrIdx_q <= wrIdx_d;
      rdIdx_q <= rdIdx_d;
      lost_q <= lost_d;
      full_q <= full_d;
      nearFull_q <= nearFull_d;
      setup_q <= setup_d;
      slotsLo_q <= slotsLo_d;
      slotsHi_q <= slotsHi_d;
      sysCtl_q <= sysCtl_d;
      irqEn_q <= irqEn_d;
      regAddr_q <= regAddr_d;
      outByte_q <= outByte_d;
      elemIdx_q <= elemIdx_d;
      byteSel_q <= byteSel_d;
    end
  end

  assign nearFullIrq = nearFull_q && irqEn_q[NEAR_FULL_IRQ_BIT];
  assign link.rdata = outByte_q;
endmodule

// ### src/bsf_host.sv
// host end: register port in, link frames out
`timescale 1ns/1ps
module bsf_host
  import bsf_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // link
  bsf_link_if.host link,
  // software port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData
);
  typedef enum logic {HS_IDLE = 1'b0, HS_FRAME = 1'b1} bsf_hstate_t;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bsf_hstate_t state_q, state_d;
  logic [4:0] phase_q, phase_d;
  logic lclk_q, lclk_d, lstart_q, lstart_d, lwr_q, lwr_d, lrd_q, lrd_d;
  logic [7:0] ldata_q, ldata_d, lastByte_q, lastByte_d;
  logic [31:0] rdData_q, rdData_d;
  logic [7:0] rs1_q, rs2_q, rs3_q;
  logic [1:0] op;

  assign op = wdata[OP_LSB+1:OP_LSB];

  always_comb
  begin
    state_d = state_q;
    phase_d = phase_q;
    lclk_d = lclk_q;
    lstart_d = lstart_q;
    lwr_d = lwr_q;
    lrd_d = lrd_q;
    ldata_d = ldata_q;
    lastByte_d = lastByte_q;
    rdData_d = 32'h0;
    if (rdStb && addr == HOST_STAT_OFS)
    begin
      rdData_d = {23'h0, state_q == HS_FRAME, lastByte_q};
    end
    unique case (state_q)
      HS_IDLE:
      begin
        // launches while a frame runs are dropped silently
        if (wrStb && addr == HOST_CMD_OFS)
        begin
          state_d = HS_FRAME;
          phase_d = 5'h0;
          lstart_d = (op == OP_ADDR);
          lwr_d = (op == OP_WRITE);
          lrd_d = (op == OP_READ);
          ldata_d = wdata[7:0];
        end
      end
      HS_FRAME:
      begin
        phase_d = phase_q + 5'h1;
        lclk_d = (phase_d >= LINK_HALF_CYC) &&
          (phase_d < 5'(2 * LINK_HALF_CYC));
        // slack third of the frame covers the device sync and answer
        if (phase_q == FRAME_CYC - 5'h1)
        begin
          if (lrd_q && rs2_q == rs3_q)
          begin
            lastByte_d = rs3_q;
          end
          state_d = HS_IDLE;
          lstart_d = 1'b0;
          lwr_d = 1'b0;
          lrd_d = 1'b0;
          lclk_d = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= HS_IDLE;
      phase_q <= 5'h0;
      lclk_q <= 1'b0;
      lstart_q <= 1'b0;
      lwr_q <= 1'b0;
      lrd_q <= 1'b0;
      ldata_q <= 8'h0;
      lastByte_q <= 8'h0;
      rdData_q <= 32'h0;
      rs1_q <= 8'h0;
      rs2_q <= 8'h0;
      rs3_q <= 8'h0;
    end
    else
    begin
      state_q <= state_d;
      phase_q <= phase_d;
      lclk_q <= lclk_d;
      lstart_q <= lstart_d;
      lwr_q <= lwr_d;
      lrd_q <= lrd_d;
      ldata_q <= ldata_d;
      lastByte_q <= lastByte_d;
      rdData_q <= rdData_d;
      rs1_q <= link.rdata;
      rs2_q <= rs1_q;
      rs3_q <= rs2_q;
    end
  end

  assign link.lclk = lclk_q;
  assign link.lstart = lstart_q;
  assign link.lwr = lwr_q;
  assign link.lrd = lrd_q;
  assign link.ldata = ldata_q;
  assign rdData = rdData_q;
endmodule

// ### src/bsf_link_if.sv
// link between the host controller and the sample fifo device
`timescale 1ns/1ps
interface bsf_link_if;
  logic lclk;
  logic lstart;
  logic lwr;
  logic lrd;
  logic [7:0] ldata;
  logic [7:0] rdata;
  modport dev (input lclk, input lstart, input lwr, input lrd,
    input ldata, output rdata);
  modport host (output lclk, output lstart, output lwr, output lrd,
    output ldata, input rdata);
endinterface

// ### src/bsf_pkg.sv
// shared constants and types for the biosignal sample fifo link
package bsf_pkg;
  // ------------------------------------------------------------
  // register offsets of the device
  // ------------------------------------------------------------
  localparam logic [7:0] REG_STATUS_OFS = 8'h00;
  localparam logic [7:0] REG_IRQ_EN_OFS = 8'h02;
  localparam logic [7:0] REG_WR_INDEX_OFS = 8'h04;
  localparam logic [7:0] REG_LOST_OFS = 8'h05;
  localparam logic [7:0] REG_RD_INDEX_OFS = 8'h06;
  localparam logic [7:0] REG_DATA_PORT_OFS = 8'h07;
  localparam logic [7:0] REG_SETUP_OFS = 8'h08;
  localparam logic [7:0] REG_SLOTS_LO_OFS = 8'h09;
  localparam logic [7:0] REG_SLOTS_HI_OFS = 8'h0a;
  localparam logic [7:0] REG_SYS_CTL_OFS = 8'h0d;
  localparam logic [7:0] REG_OPT_CFG_FIRST = 8'h0e;
  localparam logic [7:0] REG_OPT_CFG_LAST = 8'h11;
  localparam logic [7:0] REG_CARD_CFG_FIRST = 8'h3c;
  localparam logic [7:0] REG_CARD_CFG_LAST = 8'h3e;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int NEAR_FULL_BIT = 7;
  localparam int NEAR_FULL_IRQ_BIT = 7;
  localparam int FIFO_ENABLE_BIT = 2;
  localparam int OVERWRITE_BIT = 4;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [4:0] LOST_MAX = 5'h1f;
  localparam logic [5:0] FIFO_SAMPLES = 6'h20;
  localparam int SLOT_COUNT = 4;
  localparam int BYTES_PER_ELEM = 3;
  // ------------------------------------------------------------
  // slot source codes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    SLOT_NONE = 4'h0,
    SLOT_OPT1 = 4'h1,
    SLOT_OPT2 = 4'h2,
    SLOT_CARD = 4'h9
  } bsf_slot_t;
  // ------------------------------------------------------------
  // host controller registers and link timing
  // ------------------------------------------------------------
  localparam logic [7:0] HOST_CMD_OFS = 8'h00;
  localparam logic [7:0] HOST_STAT_OFS = 8'h04;
  localparam logic [1:0] OP_ADDR = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam int OP_LSB = 16;
  localparam int BUSY_BIT = 8;
  localparam real LINK_HALF_NS = 80.0;
  localparam real CORE_PERIOD_NS = 10.0;
  localparam logic [4:0] LINK_HALF_CYC = 5'(int'(LINK_HALF_NS / CORE_PERIOD_NS));
  localparam logic [4:0] FRAME_CYC = 5'(3 * int'(LINK_HALF_NS / CORE_PERIOD_NS));
endpackage

// ### tb/biosignal_sample_fifo_tb.sv
// bench joining host and device ends over the link
`timescale 1ns/1ps
module biosignal_sample_fifo_tb
  import bsf_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [31:0] rdData;
  logic sampleStrobe = 1'b0;
  logic proximityMode = 1'b0;
  logic [18:0] opt1Data = 19'h0;
  logic [18:0] opt2Data = 19'h0;
  logic [17:0] cardData = 18'h0;
  logic nearFullIrq;
  logic fifoEnabled;
  logic [7:0] junk;
  int errTotal = 0;
  int nChecks = 0;
  // ------------------------------------------------------------
  // both ends and the wire checker
  // ------------------------------------------------------------
  bsf_link_if link();
  bsf_host u_bsf_host(.core_clk(core_clk), .nrst(nrst), .link(link),
    .addr(addr), .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData));
  bsf_device u_bsf_device(.core_clk(core_clk), .nrst(nrst), .link(link),
    .sampleStrobe(sampleStrobe), .opt1Data(opt1Data), .opt2Data(opt2Data),
    .cardData(cardData), .proximityMode(proximityMode),
    .nearFullIrq(nearFullIrq), .fifoEnabled(fifoEnabled));
  bsf_link_properties u_bsf_link_properties(.core_clk(core_clk),
    .nrst(nrst), .lclk(link.lclk), .lstart(link.lstart), .lwr(link.lwr),
    .lrd(link.lrd), .ldata(link.ldata), .rdata(link.rdata));
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic stopTest();
    if (errTotal == 0 && nChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
    input string what);
    nChecks++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic swWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge core_clk);
    wrStb <= 1'b0;
  endtask
  task automatic swRd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge core_clk);
    rdStb <= 1'b0;
    #1 d = rdData;
  endtask
  // one frame, waited out by polling busy
  task automatic linkOp(input logic [1:0] op, input logic [7:0] v,
    output logic [7:0] r);
    logic [31:0] s;
    swWr(HOST_CMD_OFS, {14'h0, op, 8'h0, v});
    repeat (2) @(posedge core_clk);
    chk({link.lstart, link.lwr, link.lrd}, 3'b100 >> op, "frame kind");
    if (op != OP_READ)
      chk(link.ldata, v, "link byte");
    s = 32'h0;
    s[BUSY_BIT] = 1'b1;
    for (int i = 0; i < 40 && s[BUSY_BIT] !== 1'b0; i++)
      swRd(HOST_STAT_OFS, s);
    chk(s[BUSY_BIT], 1'b0, "busy");
    r = s[7:0];
  endtask
  task automatic devWr(input logic [7:0] a, input logic [7:0] d);
    linkOp(OP_ADDR, a, junk);
    linkOp(OP_WRITE, d, junk);
  endtask
  task automatic devRd(input logic [7:0] a, output logic [7:0] r);
    linkOp(OP_ADDR, a, junk);
    linkOp(OP_READ, 8'h00, r);
  endtask
  // burst over write index, lost count, read index
  task automatic idx(input logic [7:0] w, l, rr);
    logic [7:0] v;
    devRd(REG_WR_INDEX_OFS, v);
    chk(v, w, "write index");
    linkOp(OP_READ, 8'h00, v);
    chk(v, l, "lost count");
    linkOp(OP_READ, 8'h00, v);
    chk(v, rr, "read index");
  endtask
  // second optical input carries the inverse to save arguments
  task automatic push(input logic [18:0] o, input logic [17:0] c);
    @(posedge core_clk);
    opt1Data <= o;
    opt2Data <= ~o;
    cardData <= c;
    sampleStrobe <= 1'b1;
    @(posedge core_clk);
    sampleStrobe <= 1'b0;
  endtask
  // three data port bytes, masked where the top bits are undefined
  task automatic rdElem(input logic [23:0] e, input logic [23:0] m);
    logic [7:0] r;
    for (int k = 2; k >= 0; k--)
    begin
      linkOp(OP_READ, 8'h00, r);
      chk(r & m[k*8 +: 8], e[k*8 +: 8] & m[k*8 +: 8], "fifo byte");
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic tReset();
    chk(fifoEnabled, 1'b0, "fifo enable");
    idx(8'h00, 8'h00, 8'h00);
  endtask
  task automatic tOrder();
    devWr(REG_SLOTS_LO_OFS, 8'h21);
    devWr(REG_SLOTS_HI_OFS, 8'h09);
    devWr(REG_SYS_CTL_OFS, 8'h04);
    chk(fifoEnabled, 1'b1, "fifo enable");
    push(19'h5a5a5, 18'h2abcd);
    push(19'h4c3b2, 18'h1f0e1);
    idx(8'h02, 8'h00, 8'h00);
    linkOp(OP_ADDR, REG_DATA_PORT_OFS, junk);
    rdElem({5'h0, 19'h5a5a5}, 24'h07ffff);
    idx(8'h02, 8'h00, 8'h00);
    linkOp(OP_ADDR, REG_DATA_PORT_OFS, junk);
    rdElem({5'h0, 19'h5a5a5}, 24'h07ffff);
    rdElem({5'h0, ~19'h5a5a5}, 24'h07ffff);
    rdElem({6'h0, 18'h2abcd}, 24'hffffff);
    rdElem({5'h0, 19'h4c3b2}, 24'h07ffff);
    idx(8'h02, 8'h00, 8'h01);
    devWr(REG_RD_INDEX_OFS, 8'h00);
    linkOp(OP_ADDR, REG_DATA_PORT_OFS, junk);
    rdElem({5'h0, 19'h5a5a5}, 24'h07ffff);
  endtask
  task automatic tSingle();
    devWr(REG_SLOTS_LO_OFS, 8'h09);
    devWr(REG_SLOTS_HI_OFS, 8'h00);
    idx(8'h00, 8'h00, 8'h00);
    push(19'h0, 18'h3ffff);
    push(19'h0, 18'h00001);
    linkOp(OP_ADDR, REG_DATA_PORT_OFS, junk);
    rdElem({6'h0, 18'h3ffff}, 24'hffffff);
    rdElem({6'h0, 18'h00001}, 24'hffffff);
    rdElem(24'h0, 24'hffffff);
    idx(8'h02, 8'h00, 8'h02);
  endtask
  task automatic tFull();
    logic [7:0] r;
    devWr(REG_SLOTS_LO_OFS, 8'h01);
    devWr(REG_IRQ_EN_OFS, 8'h80);
    for (int i = 0; i < 33; i++)
      push(19'(i + 1), 18'h0);
    idx(8'h00, 8'h01, 8'h00);
    chk(nearFullIrq, 1'b1, "near full irq");
    linkOp(OP_ADDR, REG_DATA_PORT_OFS, junk);
    rdElem({5'h0, 19'h1}, 24'h07ffff);
    idx(8'h00, 8'h00, 8'h01);
    devWr(REG_SETUP_OFS, 8'h10);
    push(19'h40, 18'h0);
    push(19'h41, 18'h0);
    idx(8'h02, 8'h01, 8'h02);
    linkOp(OP_ADDR, REG_DATA_PORT_OFS, junk);
    rdElem({5'h0, 19'h3}, 24'h07ffff);
    devRd(REG_STATUS_OFS, r);
    chk(r[NEAR_FULL_BIT], 1'b1, "near full flag");
    chk(nearFullIrq, 1'b0, "near full irq");
    repeat (34) push(19'h7, 18'h0);
    devWr(REG_LOST_OFS, 8'h00);
    idx(8'h04, 8'h1f, 8'h04);
  endtask
  task automatic tProx();
    logic [7:0] r;
    @(posedge core_clk);
    proximityMode <= 1'b1;
    repeat (8) @(posedge core_clk);
    idx(8'h00, 8'h1f, 8'h00);
    push(19'h11, 18'h0);
    idx(8'h01, 8'h1f, 8'h00);
    @(posedge core_clk);
    proximityMode <= 1'b0;
    repeat (8) @(posedge core_clk);
    idx(8'h00, 8'h1f, 8'h00);
    push(19'h12, 18'h0);
    devWr(REG_OPT_CFG_FIRST, 8'h00);
    idx(8'h00, 8'h1f, 8'h00);
    // threshold fourteen, stale flag cleared first
    devWr(REG_SETUP_OFS, 8'h0e);
    devRd(REG_STATUS_OFS, r);
    chk(r[NEAR_FULL_BIT], 1'b1, "near full flag");
    repeat (17) push(19'h13, 18'h0);
    @(posedge core_clk);
    chk(nearFullIrq, 1'b0, "near full irq");
    push(19'h14, 18'h0);
    // flag lands on the strobe edge, look one edge later
    @(posedge core_clk);
    chk(nearFullIrq, 1'b1, "near full irq");
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    tReset();
    tOrder();
    tSingle();
    tFull();
    tProx();
    stopTest();
  end
  // generous span: some thousand frames of 24 cycles
  initial
  begin
    #300000;
    errTotal++;
    stopTest();
  end
endmodule

// ### tb/bsf_link_properties.sv
// wire checks on the link between the host and device ends
`timescale 1ns/1ps
module bsf_link_properties
  import bsf_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // link
  input wire logic lclk,
  input wire logic lstart,
  input wire logic lwr,
  input wire logic lrd,
  input wire logic [7:0] ldata,
  input wire logic [7:0] rdata
);
  wire logic anyStb;
  assign anyStb = lstart | lwr | lrd;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // ------------------------------------------------------------
  // frame phases
  // ------------------------------------------------------------
  sequence lead_s;
    !lclk [*8] ##1 lclk;
  endsequence
  sequence high_s;
    lclk [*8] ##1 !lclk;
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_idle_low: assert property (!anyStb |-> !lclk)
    else $error("link clock high outside a frame");
  chk_one_kind: assert property ($onehot0({lstart, lwr, lrd}))
    else $error("two frame kinds at once");
  chk_frame_stable: assert property (lclk |-> $stable({anyStb, ldata}))
    else $error("frame changed while link clock high");
  chk_clk_lead: assert property ($rose(anyStb) |-> lead_s)
    else $error("link clock rise not eight cycles after frame start");
  chk_clk_high: assert property ($rose(lclk) |-> high_s)
    else $error("link clock high phase not eight cycles");
  chk_frame_len: assert property ($rose(anyStb) |->
    anyStb [*8] ##[1:20] !anyStb)
    else $error("frame length out of bounds");
  // only reads may move the returned byte
  chk_rd_only: assert property ($changed(rdata) |-> lrd)
    else $error("read byte changed outside a read frame");
  chk_rd_timing: assert property ($changed(rdata) |->
    lclk && $past(lclk, 3))
    else $error("read byte changed at the wrong moment");
endmodule
